// *** pmc_pkg.sv ***
// Constants for the PLL miscellaneous control bits
package pmc_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] PLL_MISC_CONTROL_ADDR = 10'h01d;
    localparam logic [ADDR_W-1:0] PLL_STATUS_ADDR = 10'h01f;
    localparam logic [DATA_W-1:0] PLL_MISC_CONTROL_RESET = 8'h80;
    localparam int BIT_EEPROM_STATUS_SEL = 7;
    localparam int BIT_CRYSTAL_AMP_EN = 6;
    localparam int BIT_DOUBLER_EN = 5;
    localparam int BIT_STATUS_READBACK_DIS = 4;
    localparam int BIT_LOCK_CMP_EN = 3;
    localparam int BIT_EXT_HOLDOVER_EN = 1;
    localparam int BIT_HOLDOVER_EN = 0;
    localparam int RESERVED_BIT = 2;
endpackage : pmc_pkg

// *** pmc_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pmc_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pin side
    input wire logic pin_in,
    // Clock domain side
    output logic pin_out
);
    logic s1;
    logic s2;
    logic s3;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Output moves only when the last two stages agree
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_out <= 1'b0;
        end else if (s2 == s3) begin
            pin_out <= s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    agree_follow_a: assert property (@(posedge clk) disable iff (srst)
        (s2 == s3) |=> (pin_out == $past(s3)))
        else $error("synchronised pin did not follow agreeing stages");
endmodule : pmc_pin_sync

// *** pmc_misc_ctrl.sv ***
// PLL miscellaneous control register with status pin, readback and lock-detect logic
// Operation
// - With the status select bit clear, the status pin follows the general status selection.
// - With the status select bit set, its default, the status pin carries the EEPROM status.
// - Bit 6 set enables the crystal oscillator amplifier, default off.
// - Bit 5 set enables the reference clock doubler, default off.
// - With bit 4 clear, its default, the PLL status readback keeps updating.
// - With bit 4 set, the PLL status readback is frozen and no longer updated.
// - With bit 3 clear, the lock-detect comparator is off and holdover sees the pin as high.
// - With bit 3 set in automatic holdover, holdover uses the comparator result.
// - Outside automatic holdover the enabled comparator result is visible on the reference monitor pin.
// - Setting the external holdover bit gives holdover to the sync pin and stops internal mode.
`timescale 1ns/1ns
module pmc_misc_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register access port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pmc_pkg::DATA_W-1:0] reg_wdata,
    output logic [pmc_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rd_valid,
    // Status sources
    input wire logic eeprom_status,
    input wire logic status_sel_signal,
    input wire logic [pmc_pkg::DATA_W-1:0] pll_status,
    input wire logic lock_detect_pin,
    input wire logic sync_pin_holdover,
    // Outputs to the analog and pin logic
    output logic status_pin,
    output logic crystal_oscillator_amp_en,
    output logic ref_doubler_en,
    output logic lock_cmp_en,
    output logic holdover_was_locked,
    output logic reference_monitor_pin,
    output logic internal_holdover_en,
    output logic external_holdover_en,
    output logic holdover_request
);
    logic [pmc_pkg::DATA_W-1:0] ctrl;
    logic [pmc_pkg::DATA_W-1:0] pll_status_q;
    logic lock_cmp;
    logic auto_holdover;

    function automatic logic addr_hit(input logic [pmc_pkg::ADDR_W-1:0] a,
                                      input logic [pmc_pkg::ADDR_W-1:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    pmc_pin_sync u_lock_sync (
        .clk(clk),
        .srst(srst),
        .pin_in(lock_detect_pin),
        .pin_out(lock_cmp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // hold until write
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= pmc_pkg::PLL_MISC_CONTROL_RESET;
        end else if (reg_wr_en && addr_hit(reg_addr, pmc_pkg::PLL_MISC_CONTROL_ADDR)) begin
            ctrl <= reg_wdata;
            ctrl[pmc_pkg::RESERVED_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pll_status_q <= '0;
        end else if (!ctrl[pmc_pkg::BIT_STATUS_READBACK_DIS]) begin
            pll_status_q <= pll_status;
        end
    end

    // Read answers one cycle later; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= '0;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (!reg_rd_en) begin
                reg_rdata <= '0;
            end else if (addr_hit(reg_addr, pmc_pkg::PLL_MISC_CONTROL_ADDR)) begin
                reg_rdata <= ctrl;
            end else if (addr_hit(reg_addr, pmc_pkg::PLL_STATUS_ADDR)) begin
                reg_rdata <= pll_status_q;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external mode disables internal
    assign auto_holdover = ctrl[pmc_pkg::BIT_HOLDOVER_EN] && !ctrl[pmc_pkg::BIT_EXT_HOLDOVER_EN];

    always_ff @(posedge clk) begin
        if (srst) begin
            status_pin <= 1'b0;
        end else if (ctrl[pmc_pkg::BIT_EEPROM_STATUS_SEL]) begin
            status_pin <= eeprom_status;
        end else begin
            status_pin <= status_sel_signal;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            crystal_oscillator_amp_en <= 1'b0;
            ref_doubler_en <= 1'b0;
        end else begin
            crystal_oscillator_amp_en <= ctrl[pmc_pkg::BIT_CRYSTAL_AMP_EN];
            ref_doubler_en <= ctrl[pmc_pkg::BIT_DOUBLER_EN];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lock_cmp_en <= 1'b0;
            holdover_was_locked <= 1'b1;
            reference_monitor_pin <= 1'b0;
        end else begin
            lock_cmp_en <= ctrl[pmc_pkg::BIT_LOCK_CMP_EN];
            holdover_was_locked <= ctrl[pmc_pkg::BIT_LOCK_CMP_EN] ? lock_cmp : 1'b1;
            reference_monitor_pin <= ctrl[pmc_pkg::BIT_LOCK_CMP_EN] && !auto_holdover
                                     && lock_cmp;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            internal_holdover_en <= 1'b0;
            external_holdover_en <= 1'b0;
            holdover_request <= 1'b0;
        end else begin
            internal_holdover_en <= auto_holdover;
            external_holdover_en <= ctrl[pmc_pkg::BIT_EXT_HOLDOVER_EN];
            holdover_request <= ctrl[pmc_pkg::BIT_EXT_HOLDOVER_EN] && sync_pin_holdover;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence ctrl_write_s;
        reg_wr_en && addr_hit(reg_addr, pmc_pkg::PLL_MISC_CONTROL_ADDR);
    endsequence

    sequence no_write_s;
        !(reg_wr_en && addr_hit(reg_addr, pmc_pkg::PLL_MISC_CONTROL_ADDR));
    endsequence

    status_sel_a: assert property (@(posedge clk) disable iff (srst)
        !ctrl[pmc_pkg::BIT_EEPROM_STATUS_SEL] |=> (status_pin == $past(status_sel_signal)))
        else $error("status pin not driven from general selection");

    status_eeprom_a: assert property (@(posedge clk) disable iff (srst)
        ctrl[pmc_pkg::BIT_EEPROM_STATUS_SEL] |=> (status_pin == $past(eeprom_status)))
        else $error("status pin not driven from EEPROM status");

    crystal_amp_a: assert property (@(posedge clk) disable iff (srst)
        ctrl_write_s ##1 no_write_s |=>
        (crystal_oscillator_amp_en == $past(reg_wdata[pmc_pkg::BIT_CRYSTAL_AMP_EN], 2)))
        else $error("crystal amplifier enable does not follow write");

    doubler_en_a: assert property (@(posedge clk) disable iff (srst)
        ctrl_write_s ##1 no_write_s |=>
        (ref_doubler_en == $past(reg_wdata[pmc_pkg::BIT_DOUBLER_EN], 2)))
        else $error("doubler enable does not follow write");

    readback_track_a: assert property (@(posedge clk) disable iff (srst)
        !ctrl[pmc_pkg::BIT_STATUS_READBACK_DIS] |=> (pll_status_q == $past(pll_status)))
        else $error("status readback not updating");

    readback_freeze_a: assert property (@(posedge clk) disable iff (srst)
        ctrl[pmc_pkg::BIT_STATUS_READBACK_DIS] |=> $stable(pll_status_q))
        else $error("status readback changed while disabled");

    lock_ignore_a: assert property (@(posedge clk) disable iff (srst)
        !ctrl[pmc_pkg::BIT_LOCK_CMP_EN] |=> (holdover_was_locked && !reference_monitor_pin))
        else $error("lock-detect pin not ignored while comparator off");

    lock_use_a: assert property (@(posedge clk) disable iff (srst)
        ctrl[pmc_pkg::BIT_LOCK_CMP_EN] && auto_holdover |=> (holdover_was_locked == $past(lock_cmp)))
        else $error("holdover ignores comparator result");

    lock_monitor_a: assert property (@(posedge clk) disable iff (srst)
        ctrl[pmc_pkg::BIT_LOCK_CMP_EN] && !auto_holdover |=>
        (reference_monitor_pin == $past(lock_cmp)))
        else $error("comparator result not on monitor pin");

    ext_holdover_a: assert property (@(posedge clk) disable iff (srst)
        ctrl[pmc_pkg::BIT_EXT_HOLDOVER_EN] |=>
        (!internal_holdover_en && holdover_request == $past(sync_pin_holdover)))
        else $error("external holdover did not take control");

    ctrl_readback_a: assert property (@(posedge clk) disable iff (srst)
        reg_rd_en && addr_hit(reg_addr, pmc_pkg::PLL_MISC_CONTROL_ADDR) |=>
        (reg_rd_valid && reg_rdata == $past(ctrl)))
        else $error("control register read returned wrong value");

    status_readback_a: assert property (@(posedge clk) disable iff (srst)
        reg_rd_en && addr_hit(reg_addr, pmc_pkg::PLL_STATUS_ADDR) |=>
        (reg_rd_valid && reg_rdata == $past(pll_status_q)))
        else $error("status readback read returned wrong value");

    read_idle_a: assert property (@(posedge clk) disable iff (srst)
        !reg_rd_en |=> (!reg_rd_valid && reg_rdata == '0))
        else $error("read port not idle without a read");

    reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
        ctrl_write_s |=> !ctrl[pmc_pkg::RESERVED_BIT])
        else $error("reserved control bit not cleared");

    ctrl_hold_a: assert property (@(posedge clk) disable iff (srst)
        no_write_s |=> $stable(ctrl))
        else $error("control bits changed without a write");

    ctrl_reset_a: assert property (@(posedge clk)
        srst |=> (ctrl == pmc_pkg::PLL_MISC_CONTROL_RESET))
        else $error("control bits not at default after reset");
endmodule : pmc_misc_ctrl

// *** pmc_src_model.sv ***
// Model of the analog sources feeding the control bits
`timescale 1ns/1ns
module pmc_src_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Wanted level of the lock-detect pin
    input wire logic lock_level,
    // Source outputs
    output logic [pmc_pkg::DATA_W-1:0] pll_status,
    output logic lock_detect_pin
);
    // Live status changes every cycle so a frozen snapshot is easy to tell apart
    always_ff @(posedge clk) begin
        if (srst) begin
            pll_status <= 8'h00;
        end else begin
            pll_status <= pll_status + 8'h01;
        end
    end

    // Pin settles a little after the edge, as an analog level would
    assign #1 lock_detect_pin = lock_level;
endmodule : pmc_src_model

// *** pll_misc_control_bits_test.sv ***
// Register-level test of the PLL miscellaneous control bits
`timescale 1ns/1ns
module pll_misc_control_bits_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [pmc_pkg::ADDR_W-1:0] reg_addr = 10'h000;
    logic [pmc_pkg::DATA_W-1:0] reg_wdata = 8'h00;
    logic [pmc_pkg::DATA_W-1:0] reg_rdata;
    logic reg_rd_valid;
    logic eeprom_status = 1'b1;
    logic status_sel_signal = 1'b0;
    logic [pmc_pkg::DATA_W-1:0] pll_status;
    logic lock_detect_pin;
    logic lock_level = 1'b0;
    logic sync_pin_holdover = 1'b0;
    logic status_pin, crystal_oscillator_amp_en, ref_doubler_en, lock_cmp_en;
    logic holdover_was_locked, reference_monitor_pin, internal_holdover_en;
    logic external_holdover_en, holdover_request;
    logic [7:0] a, b;
    int miscompares = 0;
    int n_checks = 0;
    localparam logic [9:0] CTRL = pmc_pkg::PLL_MISC_CONTROL_ADDR;
    localparam logic [9:0] STAT = pmc_pkg::PLL_STATUS_ADDR;

    initial forever #2 clk = ~clk;

    pmc_src_model pmc_src_model_inst (.clk(clk), .srst(srst), .lock_level(lock_level),
        .pll_status(pll_status), .lock_detect_pin(lock_detect_pin));

    pmc_misc_ctrl pmc_misc_ctrl_inst (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .eeprom_status(eeprom_status),
        .status_sel_signal(status_sel_signal), .pll_status(pll_status),
        .lock_detect_pin(lock_detect_pin), .sync_pin_holdover(sync_pin_holdover),
        .status_pin(status_pin), .crystal_oscillator_amp_en(crystal_oscillator_amp_en),
        .ref_doubler_en(ref_doubler_en), .lock_cmp_en(lock_cmp_en),
        .holdover_was_locked(holdover_was_locked),
        .reference_monitor_pin(reference_monitor_pin),
        .internal_holdover_en(internal_holdover_en),
        .external_holdover_en(external_holdover_en), .holdover_request(holdover_request));

    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task reg_write(input logic [9:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask : reg_write

    // Waits a bounded time for the read answer
    task reg_read(input logic [9:0] addr, output logic [7:0] data);
        int i;
        data = 8'h00;
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        for (i = 0; i < 4; i++) begin
            #1;
            if (reg_rd_valid === 1'b1) begin
                data = reg_rdata;
                return;
            end
            @(posedge clk);
        end
        miscompares++;
        finish_test();
    endtask : reg_read

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        reg_read(CTRL, a);
        chk(a, 8'h80);
        chk(8'(status_pin), 8'h01);
        chk(8'(crystal_oscillator_amp_en), 8'h00);
        chk(8'(ref_doubler_en), 8'h00);
        @(posedge clk) eeprom_status <= 1'b0;
        settle(2);
        chk(8'(status_pin), 8'h00);
        reg_write(CTRL, 8'h00);
        settle(2);
        chk(8'(status_pin), 8'h00);
        @(posedge clk) status_sel_signal <= 1'b1;
        settle(2);
        chk(8'(status_pin), 8'h01);
        reg_write(CTRL, 8'h64);
        reg_read(CTRL, a);
        chk(a, 8'h60);
        chk(8'(crystal_oscillator_amp_en), 8'h01);
        chk(8'(ref_doubler_en), 8'h01);
        reg_read(STAT, a);
        reg_read(STAT, b);
        chk(b - a, 8'h02);
        reg_write(CTRL, 8'h10);
        reg_read(STAT, a);
        settle(5);
        reg_read(STAT, b);
        chk(b, a);
        reg_write(CTRL, 8'h00);
        settle(8);
        chk(8'(holdover_was_locked), 8'h01);
        chk(8'(lock_cmp_en), 8'h00);
        chk(8'(reference_monitor_pin), 8'h00);
        reg_write(CTRL, 8'h09);
        settle(8);
        chk(8'(holdover_was_locked), 8'h00);
        chk(8'(reference_monitor_pin), 8'h00);
        chk(8'(internal_holdover_en), 8'h01);
        @(posedge clk) lock_level <= 1'b1;
        settle(8);
        chk(8'(holdover_was_locked), 8'h01);
        reg_write(CTRL, 8'h08);
        settle(8);
        chk(8'(reference_monitor_pin), 8'h01);
        chk(8'(lock_cmp_en), 8'h01);
        @(posedge clk) sync_pin_holdover <= 1'b1;
        reg_write(CTRL, 8'h0b);
        settle(3);
        chk(8'(internal_holdover_en), 8'h00);
        chk(8'(external_holdover_en), 8'h01);
        chk(8'(holdover_request), 8'h01);
        reg_write(10'h017, 8'hff);
        reg_read(CTRL, a);
        chk(a, 8'h0b);
        reg_read(10'h3ff, a);
        chk(a, 8'h00);
        @(posedge clk) srst <= 1'b1;
        settle(2);
        @(posedge clk) srst <= 1'b0;
        reg_read(CTRL, a);
        chk(a, 8'h80);
        finish_test();
    end
endmodule : pll_misc_control_bits_test
